// ==== hdl/sfph_pkg.sv ====
// Constants, types and helpers shared by the flash protect and hold logic.
// Assumes one system clock of 125 MHz that samples every serial pin.
package sfph_pkg;

   // System clock and power-up write delay
   localparam int CLK_NS     = 8;
   localparam int PUW_NS     = 100000;  // Arbitrary default
   localparam int PUW_CYCLES = (PUW_NS + CLK_NS - 1) / CLK_NS;
   localparam int PUW_W      = 20;

   // Array geometry
   localparam int ARRAY_BYTES = 4194304;
   localparam int PAGE_BYTES  = 256;
   localparam int NUM_PAGES   = 16384;
   localparam int NUM_SECTORS = 64;
   localparam int SECT_BYTES  = 65536;
   localparam int ADDR_W      = 22;
   localparam int SECT_W      = 6;
   localparam int SECT_LSB    = 16;

   // Instruction codes
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ   = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE  = 8'hd8;
   localparam logic [7:0] OP_BULK_ERASE    = 8'hc7;
   localparam logic [7:0] OP_DEEP_DOWN     = 8'hb9;
   localparam logic [7:0] OP_RELEASE       = 8'hab;
   localparam logic [7:0] OP_NONE          = 8'h00;

   // Bytes per frame, opcode included
   localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
   localparam logic [2:0] LEN_SECTOR_ERASE = 3'h4;
   localparam logic [2:0] LEN_PROGRAM_MIN  = 3'h5;
   localparam logic [2:0] LEN_SINGLE       = 3'h1;
   localparam logic [2:0] LEN_SATURATE     = 3'h7;

   // Status byte layout and reset values
   localparam int ST_BUSY   = 0;
   localparam int ST_LATCH  = 1;
   localparam int ST_BP_LSB = 2;
   localparam int ST_LOCK   = 7;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [2:0] BP_NONE    = 3'h0;

   // Internal cycles; there is deliberately no page erase
   typedef enum logic [1:0] {
      CYC_STATUS,
      CYC_PROGRAM,
      CYC_SECTOR,
      CYC_BULK
   } sfph_cyc_e;

   // First protected sector for a protect code; 64 means none
   function automatic logic [6:0] sfphFirstProt(input logic [2:0] bp);
      case (bp)
         3'h0:    sfphFirstProt = 7'h40;
         3'h1:    sfphFirstProt = 7'h3f;
         3'h2:    sfphFirstProt = 7'h3e;
         3'h3:    sfphFirstProt = 7'h3c;
         3'h4:    sfphFirstProt = 7'h38;
         3'h5:    sfphFirstProt = 7'h30;
         3'h6:    sfphFirstProt = 7'h20;
         default: sfphFirstProt = 7'h00;
      endcase
   endfunction : sfphFirstProt

   // Status byte as seen by software
   function automatic logic [7:0] sfphStatus(input logic busy,
      input logic latch, input logic [2:0] bp, input logic lock);
      sfphStatus = STATUS_RST;
      sfphStatus[ST_BUSY] = busy;
      sfphStatus[ST_LATCH] = latch;
      sfphStatus[ST_BP_LSB +: 3] = bp;
      sfphStatus[ST_LOCK] = lock;
   endfunction : sfphStatus

endpackage : sfph_pkg

// ==== hdl/sfph_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module sfph_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfph_sync_s;

   sfph_sync_s q;
   sfph_sync_s d;

   // First stage feeds only the second
   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= {RST_VAL, RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule : sfph_sync
`default_nettype wire

// ==== hdl/sfph_protect.sv ====
// Decides whether an address lies in the area shielded by a protect code.
// Assumes the address has already been captured from the serial frame.
`timescale 1ns/1ps
`default_nettype none
module sfph_protect
   import sfph_pkg::*;
(
   // Protect code and address
   input  wire logic [2:0]        bp,
   input  wire logic [ADDR_W-1:0] addr,
   // Result
   output logic                   hit
);
   logic [SECT_W-1:0] sector;

   // Sector n spans n*10000h to n*10000h+ffffh
   assign sector = addr[SECT_LSB +: SECT_W];
   assign hit = {1'b0, sector} >= sfphFirstProt(bp);
endmodule : sfph_protect
`default_nettype wire

// ==== hdl/sfph_core.sv ====
// Protect, status flag and hold logic of a serial flash, sampled on mclk.
// Assumes an engine that runs each started cycle and pulses engineDone,
// and a non-volatile store that presents its bits on nvBoot after reset.
`timescale 1ns/1ps
`default_nettype none
module sfph_core
   import sfph_pkg::*;
#(
   parameter int PUW_COUNT = PUW_CYCLES
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Serial pins
   input  wire logic              chipSelN,
   input  wire logic              sclk,
   input  wire logic              sdi,
   input  wire logic              holdN,
   input  wire logic              writeProtN,
   output logic                   sdo,
   output logic                   sdoOeN,
   // Program and erase engine
   output logic                   cycStart,
   output sfph_cyc_e              cycKind,
   output logic      [ADDR_W-1:0] cycAddr,
   output logic      [7:0]        progData,
   output logic                   progValid,
   input  wire logic              engineDone,
   // Non-volatile status store
   input  wire logic [3:0]        nvBoot,
   output logic                   nvWrite,
   output logic      [3:0]        nvData,
   // State seen by the system
   output logic      [7:0]        statusOut,
   output logic                   deepDown
);
   typedef struct packed {
      logic              loaded;
      logic [PUW_W-1:0]  pwrCnt;
      logic              pwrDone;
      logic              inDp;
      logic              busy;
      logic              writeLatchFlag;
      logic              lock;
      logic [2:0]        bp;
      logic              csPrevN;
      logic              sclkPrev;
      logic              holdActive;
      logic [2:0]        bitCnt;
      logic [2:0]        byteCnt;
      logic [7:0]        shiftIn;
      logic [7:0]        opcode;
      logic [23:0]       addr;
      logic [7:0]        wrData;
      logic              sdo;
      logic              sdoOeN;
      logic              cycStart;
      sfph_cyc_e         cycKind;
      logic [ADDR_W-1:0] cycAddr;
      logic [7:0]        progData;
      logic              progValid;
      logic              nvWrite;
      logic [3:0]        nvData;
      logic [7:0]        statusOut;
   } sfph_state_s;

   sfph_state_s q;
   sfph_state_s d;

   logic [4:0] pinS;
   logic       csNS;
   logic       sclkS;
   logic       sdiS;
   logic       holdNS;
   logic       wpNS;
   logic       protHit;
   logic       hardwareProtectState;
   logic       exeOk;
   logic       sclkRise;
   logic       sclkFall;
   logic       csRise;
   logic [7:0] inByte;
   logic [7:0] stat;

   // Two flops per pin, reset to idle levels so no false edge follows
   sfph_sync #(
      .W       (5),
      .RST_VAL (5'h17)
   ) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .din  ({chipSelN, sclk, sdi, holdN, writeProtN}),
      .dout (pinS)
   );

   assign {csNS, sclkS, sdiS, holdNS, wpNS} = pinS;

   sfph_protect u_protect (
      .bp   (q.bp),
      .addr (q.addr[ADDR_W-1:0]),
      .hit  (protHit)
   );

   assign hardwareProtectState = q.lock & ~wpNS;
   assign sclkRise = sclkS & ~q.sclkPrev;
   assign sclkFall = ~sclkS & q.sclkPrev;
   assign csRise = csNS & ~q.csPrevN;
   assign inByte = {q.shiftIn[6:0], sdiS};
   assign stat = sfphStatus(q.busy, q.writeLatchFlag, q.bp, q.lock);
   // A frame counts only when it ends on a byte boundary, out of pause
   assign exeOk = csRise & ~q.holdActive & q.pwrDone & q.loaded &
                  (q.bitCnt == 3'h0) & (q.byteCnt != 3'h0);

   always_comb begin
      d = q;
      d.cycStart = 1'b0;
      d.progValid = 1'b0;
      d.nvWrite = 1'b0;
      d.sclkPrev = sclkS;
      d.csPrevN = csNS;
      // Stored bits are read back once after reset
      if (!q.loaded) begin
         d.loaded = 1'b1;
         d.lock = nvBoot[3];
         d.bp = nvBoot[2:0];
      end
      if (!q.pwrDone) begin
         if (q.pwrCnt >= PUW_W'(PUW_COUNT - 1)) begin
            d.pwrDone = 1'b1;
         end else begin
            d.pwrCnt = q.pwrCnt + 1'b1;
         end
      end
      // Pause has no effect here, so a running cycle always finishes
      if (q.busy && engineDone) begin
         d.busy = 1'b0;
      end
      if (exeOk) begin
         if (q.opcode == OP_RELEASE) begin
            d.inDp = 1'b0;
         end else if (!q.inDp && !q.busy) begin
            case (q.opcode)
               OP_WRITE_ENABLE: begin
                  d.writeLatchFlag = 1'b1;
               end
               OP_WRITE_DISABLE: begin
                  d.writeLatchFlag = 1'b0;
               end
               OP_DEEP_DOWN: begin
                  d.inDp = 1'b1;
               end
               OP_STATUS_WRITE: begin
                  // Frozen bits: refused whole while the pin locks them
                  if (q.writeLatchFlag && !hardwareProtectState &&
                      q.byteCnt == LEN_STATUS_WRITE) begin
                     d.lock = q.wrData[ST_LOCK];
                     d.bp = q.wrData[ST_BP_LSB +: 3];
                     d.nvWrite = 1'b1;
                     d.nvData = {q.wrData[ST_LOCK],
                                 q.wrData[ST_BP_LSB +: 3]};
                     d.writeLatchFlag = 1'b0;
                     d.busy = 1'b1;
                     d.cycStart = 1'b1;
                     d.cycKind = CYC_STATUS;
                  end
               end
               OP_PAGE_PROGRAM: begin
                  if (q.writeLatchFlag && !protHit &&
                      q.byteCnt >= LEN_PROGRAM_MIN) begin
                     d.writeLatchFlag = 1'b0;
                     d.busy = 1'b1;
                     d.cycStart = 1'b1;
                     d.cycKind = CYC_PROGRAM;
                     d.cycAddr = q.addr[ADDR_W-1:0];
                  end
               end
               OP_SECTOR_ERASE: begin
                  if (q.writeLatchFlag && !protHit &&
                      q.byteCnt == LEN_SECTOR_ERASE) begin
                     d.writeLatchFlag = 1'b0;
                     d.busy = 1'b1;
                     d.cycStart = 1'b1;
                     d.cycKind = CYC_SECTOR;
                     d.cycAddr = q.addr[ADDR_W-1:0];
                  end
               end
               OP_BULK_ERASE: begin
                  if (q.writeLatchFlag && q.bp == BP_NONE &&
                      q.byteCnt == LEN_SINGLE) begin
                     d.writeLatchFlag = 1'b0;
                     d.busy = 1'b1;
                     d.cycStart = 1'b1;
                     d.cycKind = CYC_BULK;
                     d.cycAddr = '0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (csNS) begin
         // Deselect clears the frame, and any pause with it
         d.holdActive = 1'b0;
         d.bitCnt = 3'h0;
         d.byteCnt = 3'h0;
         d.opcode = OP_NONE;
      end else begin
         // Pause follows the pin only while the clock is low
         if (!sclkS) begin
            d.holdActive = ~holdNS;
         end
         // Counters simply stand still while paused
         if (!q.holdActive) begin
            if (sclkRise) begin
               d.shiftIn = inByte;
               d.bitCnt = q.bitCnt + 3'h1;
               if (q.bitCnt == 3'h7) begin
                  if (q.byteCnt == 3'h0) begin
                     d.opcode = inByte;
                  end else if (q.byteCnt <= 3'h3) begin
                     d.addr = {q.addr[15:0], inByte};
                  end
                  if (q.byteCnt == 3'h1) begin
                     d.wrData = inByte;
                  end
                  // Bytes go to the page buffer; only cycStart commits
                  if (q.byteCnt >= 3'h4 &&
                      q.opcode == OP_PAGE_PROGRAM) begin
                     d.progData = inByte;
                     d.progValid = 1'b1;
                  end
                  if (q.byteCnt != LEN_SATURATE) begin
                     d.byteCnt = q.byteCnt + 3'h1;
                  end
               end
            end
            if (sclkFall && q.opcode == OP_STATUS_READ &&
                q.byteCnt != 3'h0) begin
               d.sdo = stat[3'h7 - q.bitCnt];
            end
         end
      end
      d.sdoOeN = ~(~csNS & ~d.holdActive & ~q.inDp &
                   d.opcode == OP_STATUS_READ &
                   d.byteCnt != 3'h0);
      d.statusOut = sfphStatus(d.busy, d.writeLatchFlag, d.bp, d.lock);
   end

   // Reset clears the latch; stored bits reload one cycle later
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.sdoOeN <= 1'b1;
         q.sclkPrev <= 1'b0;
         q.csPrevN <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign sdo = q.sdo;
   assign sdoOeN = q.sdoOeN;
   assign cycStart = q.cycStart;
   assign cycKind = q.cycKind;
   assign cycAddr = q.cycAddr;
   assign progData = q.progData;
   assign progValid = q.progValid;
   assign nvWrite = q.nvWrite;
   assign nvData = q.nvData;
   assign statusOut = q.statusOut;
   assign deepDown = q.inDp;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   AST_BUSY_CLEARS: assert property (
      q.busy && engineDone |=> !q.busy)
      else $error("busy flag did not clear on engine done");
   AST_LATCH_CLEARED: assert property (
      q.cycStart |-> !q.writeLatchFlag && $past(q.writeLatchFlag))
      else $error("cycle started without latch or latch kept");
   AST_BYTE_BOUND: assert property (
      q.cycStart |-> $past(q.bitCnt) == 3'h0 && $past(csRise))
      else $error("cycle started off a byte boundary");
   AST_BULK_CODE: assert property (
      q.cycStart && q.cycKind == CYC_BULK |-> $past(q.bp) == BP_NONE)
      else $error("bulk erase with protect code set");
   AST_DEEP_IGNORE: assert property (
      q.inDp |=> !q.cycStart)
      else $error("cycle started in deep power-down");
   AST_HW_FROZEN: assert property (
      q.loaded && hardwareProtectState |=> $stable({q.lock, q.bp}))
      else $error("protect bits changed in hardware protect");
   AST_PROT_AREA: assert property (
      q.cycStart && (q.cycKind == CYC_PROGRAM || q.cycKind == CYC_SECTOR)
      |-> !$past(protHit))
      else $error("program or erase in a protected sector");
   AST_PUW_BLOCK: assert property (
      !q.pwrDone |=> !q.cycStart)
      else $error("cycle started before power-up delay");
   AST_HOLD_ENTER: assert property (
      !csNS && !sclkS && !holdNS |=> q.holdActive)
      else $error("pause not entered with clock low");
   AST_HOLD_FLOAT: assert property (
      q.holdActive |-> q.sdoOeN)
      else $error("output driven while paused");
   AST_HOLD_FREEZE: assert property (
      q.holdActive && !csNS |=> $stable({q.bitCnt, q.byteCnt}))
      else $error("bit position moved while paused");

   COV_PROGRAM: cover property (q.cycStart && q.cycKind == CYC_PROGRAM);
   COV_STATUS: cover property (q.cycStart && q.cycKind == CYC_STATUS);
   COV_BULK: cover property (q.cycStart && q.cycKind == CYC_BULK);
   COV_HOLD: cover property (q.holdActive ##1 !q.holdActive);
endmodule : sfph_core
`default_nettype wire

// ==== testbench/sfph_host_model.sv ====
// Behavioural bus controller driving the serial pins in mode 0.
// Assumes mclk at 125 MHz; each sclk phase lasts four mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module sfph_host_model (
   // Clock
   input  wire logic mclk,
   // Serial pins
   output logic      chipSelN,
   output logic      sclk,
   output logic      sdi,
   output logic      holdN,
   input  wire logic sdo,
   input  wire logic sdoOeN
);
   initial begin
      chipSelN = 1'b1;
      sclk     = 1'b0;
      sdi      = 1'b0;
      holdN    = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   // Shift nb bits MSB first; at bit holdAt pause with noise on sclk/sdi
   task automatic frame(input logic [39:0] d, input int nb, input int holdAt,
                        input bit abort, output logic [7:0] rd,
                        output logic floated);
      rd      = 8'h00;
      floated = 1'b1;
      @(posedge mclk);
      chipSelN <= 1'b0;
      tick(4);
      for (int i = 0; i < nb; i++) begin
         if (i == holdAt) begin
            holdN <= 1'b0; // Selected and sclk low
            tick(4);
            repeat (4) begin
               sclk <= ~sclk;
               sdi  <= ~sdi;
               tick(3);
               @(negedge mclk);
               floated &= (sdoOeN === 1'b1);
               @(posedge mclk);
            end
            if (abort) begin
               chipSelN <= 1'b1; // Deselect while paused
               tick(6);
               holdN <= 1'b1; // Release pause before reselecting
               tick(6);
               return;
            end
            holdN <= 1'b1; // Still selected, sclk low
            tick(4);
         end
         sdi <= d[39-i];
         tick(3);
         @(negedge mclk);
         // A floated line reads as the inverse of sdo, not as the last driven bit
         rd = {rd[6:0], (sdoOeN === 1'b0) ? sdo : ~sdo};
         @(posedge mclk);
         sclk <= 1'b1;
         tick(4);
         sclk <= 1'b0;
      end
      tick(4);
      chipSelN <= 1'b1;
      sdi      <= ~sdi; // Released line does not keep the last value
      tick(8);
   endtask : frame
endmodule : sfph_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench: host model on the pins, engine and store models here.
// Assumes a shortened power-up delay so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import sfph_pkg::*;
   localparam int PUW = 200;
   logic              mclk, rst, writeProtN, engineDone, sdo, sdoOeN;
   logic              chipSelN, sclk, sdi, holdN, cycStart, progValid;
   logic              nvWrite, deepDown, fl;
   logic [3:0]        nvBoot, nvData;
   logic [7:0]        progData, statusOut, lastData, rd;
   logic [ADDR_W-1:0] cycAddr, lastAddr;
   sfph_cyc_e         cycKind, lastKind;
   int                starts, s0, engCnt, engDelay, first;
   int                miscompares, tests_run;

   sfph_host_model h (.mclk(mclk), .chipSelN(chipSelN), .sclk(sclk),
      .sdi(sdi), .holdN(holdN), .sdo(sdo), .sdoOeN(sdoOeN));
   sfph_core #(.PUW_COUNT(PUW)) i_dut (.mclk(mclk), .rst(rst),
      .chipSelN(chipSelN), .sclk(sclk), .sdi(sdi), .holdN(holdN),
      .writeProtN(writeProtN), .sdo(sdo), .sdoOeN(sdoOeN),
      .cycStart(cycStart), .cycKind(cycKind), .cycAddr(cycAddr),
      .progData(progData), .progValid(progValid), .engineDone(engineDone),
      .nvBoot(nvBoot), .nvWrite(nvWrite), .nvData(nvData),
      .statusOut(statusOut), .deepDown(deepDown));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Engine finishes engDelay cycles after a start; store keeps its bits
   always @(posedge mclk) begin
      engineDone <= 1'b0;
      if (rst) begin
         starts <= 0;
         engCnt <= 0;
         nvBoot <= 4'h0;
      end else if (cycStart) begin
         starts   <= starts + 1;
         lastKind <= cycKind;
         lastAddr <= cycAddr;
         engCnt   <= engDelay;
      end else if (engCnt != 0) begin
         engCnt <= engCnt - 1;
         if (engCnt == 1)
            engineDone <= 1'b1;
      end
      if (nvWrite)
         nvBoot <= nvData;
      if (progValid)
         lastData <= progData;
   end

   task automatic cmd(input logic [39:0] d, input int nb);
      h.frame(d, nb, 99, 1'b0, rd, fl);
      repeat (6) @(posedge mclk);
   endtask : cmd

   task automatic waitIdle();
      int n;
      n = 0;
      while (statusOut[ST_BUSY] !== 1'b0 && n < 5000) begin
         @(posedge mclk);
         n++;
      end
      `CHK(statusOut[ST_BUSY], 1'b0)
   endtask : waitIdle

   task automatic writeEn();
      cmd({OP_WRITE_ENABLE, 32'h0}, 8);
   endtask : writeEn

   task automatic statusWr(input logic [7:0] v);
      writeEn();
      cmd({OP_STATUS_WRITE, v, 24'h0}, 16);
      waitIdle();
   endtask : statusWr

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   initial begin
      #400000;
      miscompares++;
      print_verdict();
   end

   initial begin
      rst         = 1'b1;
      writeProtN  = 1'b1;
      engDelay    = 40;
      miscompares = 0;
      tests_run   = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      writeEn();
      `CHK(statusOut, 8'h00)
      repeat (PUW) @(posedge mclk);
      writeEn();
      `CHK(statusOut, 8'h02)
      cmd({OP_WRITE_DISABLE, 32'h0}, 8);
      `CHK(statusOut, 8'h00)
      s0 = starts;
      cmd({OP_PAGE_PROGRAM, 24'h123456, 8'ha5}, 40);
      `CHK(starts - s0, 0)
      writeEn();
      cmd({OP_PAGE_PROGRAM, 24'h123456, 8'ha5}, 40);
      `CHK(starts - s0, 1)
      `CHK({lastKind, lastAddr}, {CYC_PROGRAM, 22'h123456})
      `CHK(lastData, 8'ha5)
      `CHK(statusOut, 8'h01)
      waitIdle();
      `CHK(statusOut, 8'h00)
      writeEn();
      s0 = starts;
      cmd({OP_STATUS_WRITE, 8'h1c, 24'h0}, 17);
      `CHK(starts - s0, 0)
      `CHK(statusOut, 8'h02)
      cmd({OP_STATUS_WRITE, 8'h1c, 24'h0}, 16);
      `CHK(lastKind, CYC_STATUS)
      waitIdle();
      `CHK({statusOut, nvBoot}, {8'h1c, 4'h7})
      for (int bp = 0; bp < 8; bp++) begin
         first = (bp == 0) ? 64 : (bp == 7) ? 0 : 64 - (1 << (bp - 1));
         statusWr({3'h0, bp[2:0], 2'h0});
         writeEn();
         s0 = starts;
         if (first < 64)
            cmd({OP_SECTOR_ERASE, 2'h0, first[5:0], 16'hbeef, 8'h0}, 32);
         `CHK(starts - s0, 0)
         if (first > 0) begin
            s0 = first - 1;
            cmd({OP_SECTOR_ERASE, 2'h0, s0[5:0], 16'hbeef, 8'h0}, 32);
            `CHK(lastAddr, {s0[5:0], 16'hbeef})
            `CHK(lastKind, CYC_SECTOR)
            waitIdle();
         end
         writeEn();
         s0 = starts;
         cmd({OP_BULK_ERASE, 32'h0}, 8);
         `CHK(starts - s0, (bp == 0) ? 1 : 0)
         waitIdle();
      end
      statusWr(8'h80);
      writeProtN <= 1'b0;
      writeEn();
      s0 = starts;
      cmd({OP_STATUS_WRITE, 8'h04, 24'h0}, 16);
      `CHK(starts - s0, 0)
      `CHK(statusOut, 8'h82)
      writeProtN <= 1'b1;
      cmd({OP_STATUS_WRITE, 8'h14, 24'h0}, 16);
      waitIdle();
      `CHK(statusOut, 8'h14)
      cmd({OP_DEEP_DOWN, 32'h0}, 8);
      `CHK(deepDown, 1'b1)
      writeEn();
      s0 = starts;
      cmd({OP_PAGE_PROGRAM, 24'h000100, 8'h3c}, 40);
      `CHK(starts - s0, 0)
      cmd({OP_RELEASE, 32'h0}, 8);
      `CHK({deepDown, statusOut}, {1'b0, 8'h14})
      h.frame({OP_STATUS_READ, 32'h0}, 16, 12, 1'b0, rd, fl);
      `CHK({rd, fl}, {8'h14, 1'b1})
      h.frame({OP_WRITE_ENABLE, 32'h0}, 16, 8, 1'b1, rd, fl);
      `CHK(statusOut, 8'h14)
      writeEn();
      `CHK(statusOut, 8'h16)
      engDelay = 600;
      cmd({OP_PAGE_PROGRAM, 24'h000100, 8'h3c}, 40);
      h.frame({OP_STATUS_READ, 32'h0}, 16, 3, 1'b0, rd, fl);
      `CHK(rd, 8'h15)
      waitIdle();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
